// ===== ihap_pkg.sv
// shared constants, types and helpers of the isa host access port
// Functional notes
// - accept byte or word transfers in io and memory space over a 16-bit datapath
// - memory mode reads are random in the first 118 frame bytes, then sequential
// - memory mode decodes one 4-kbyte block aligned to X000h, space base at start
// - io mode after reset; memory enable bit A opens memory mode
// - memory cycles complete without extra wait states
// - memory access needs address in range, chip select low and a strobe low
// - 24-bit mapping: external la decode, base at 002Ch, select bit 9 set
// - first megabyte mapping: chip select tied low, select bit 9 cleared
// - command at 0144h then length at 0146h; bad length sets bid error bit 7
// - host writes the frame once bus status bit 8 shows transmit ready now
// - host reads the event queue at 0120h
// - io mode always on: eight 16-bit ports over 16 byte locations
// - io base resets to 300h and can move to any XXX0h
// - io ports: frame data 0h and 2h, command 4h and length 6h write only
// - io ports: event queue 8h read only, pointer Ah, register data Ch and Eh
// - pointer bits 0-B address, C-E read 011b, bit F auto increments
// - data port 0 carries words; ports 0 and 1 pair for 32 bits, low word first
package ihap_pkg;
    // ------------------------------------------------------------
    // io port offsets
    // ------------------------------------------------------------
    localparam logic [3:0] IO_DATA0 = 4'h0;
    localparam logic [3:0] IO_DATA1 = 4'h2;
    localparam logic [3:0] IO_TX_CMD = 4'h4;
    localparam logic [3:0] IO_TX_LEN = 4'h6;
    localparam logic [3:0] IO_EVQ = 4'h8;
    localparam logic [3:0] IO_PTR = 4'ha;
    localparam logic [3:0] IO_REG0 = 4'hc;
    localparam logic [3:0] IO_REG1 = 4'he;
    // ------------------------------------------------------------
    // register space offsets
    // ------------------------------------------------------------
    localparam logic [11:0] SP_MEM_BASE_LO = 12'h02c;
    localparam logic [11:0] SP_MEM_BASE_HI = 12'h02e;
    localparam logic [11:0] SP_EVQ = 12'h120;
    localparam logic [11:0] SP_BUS_ST = 12'h138;
    localparam logic [11:0] SP_TX_CMD = 12'h144;
    localparam logic [11:0] SP_TX_LEN = 12'h146;
    localparam logic [11:0] SP_BUS_CTL = 12'h3f0;
    localparam logic [11:0] SP_SELF_ST = 12'h3f2;
    localparam logic [11:0] SP_RX_STAT = 12'h400;
    localparam logic [11:0] SP_RX_LEN = 12'h402;
    localparam logic [11:0] SP_RX_FRAME = 12'h404;
    localparam logic [11:0] SP_TX_FRAME = 12'ha00;
    localparam logic [11:0] RX_RANDOM_BYTES = 12'd118;
    localparam logic [11:0] SP_RX_RAND_END = SP_RX_FRAME + RX_RANDOM_BYTES;
    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int BC_SYS_ADDR = 9;
    localparam int BC_MEM_EN = 10;
    localparam int BS_BID_ERR = 7;
    localparam int BS_TX_RDY = 8;
    localparam int SS_INIT_DONE = 7;
    localparam int SS_EXT_LOGIC = 11;
    localparam int PTR_AUTOINC = 15;
    localparam logic [2:0] PTR_FIXED = 3'h3;
    localparam logic [15:0] LEN_MIN = 16'h0004;
    localparam logic [15:0] LEN_MAX = 16'h05ee;
    localparam logic [11:0] PTR_STEP = 12'h002;
    localparam logic [10:0] RX_STEP_WORD = 11'h002;
    localparam logic [10:0] RX_STEP_BYTE = 11'h001;
    localparam logic [15:0] IO_BASE_RST = 16'h0300;
    localparam logic [15:0] BUS_CTL_RST = 16'h0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACT = 2'b10
    } ihap_state_t;
    typedef struct packed {
        ihap_state_t st;
        logic [15:0] io_base;
        logic [15:0] bus_ctl;
        logic [23:0] mem_base;
        logic [15:0] ptr;
        logic [10:0] rx_seq;
        logic bid_err;
        logic rd;
        logic [15:0] sd;
        logic tx_wr;
        logic [1:0] tx_be;
        logic [15:0] tx_data;
        logic tx_bid;
        logic [15:0] tx_cmd;
        logic [15:0] tx_len;
        logic reg_wr;
        logic [11:0] reg_waddr;
        logic [1:0] reg_be;
        logic [15:0] reg_wdata;
    } ihap_regs_t;
    localparam ihap_regs_t REGS_RST = '{st: ST_IDLE, io_base: IO_BASE_RST, bus_ctl: BUS_CTL_RST, default: '0};
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // swap byte lanes for an 8-bit host on an odd address
    function automatic logic [15:0] ihap_swap(input logic [15:0] d, input logic s);
        ihap_swap = s ? {d[7:0], d[15:8]} : d;
    endfunction
    // merge written byte lanes into an old word
    function automatic logic [15:0] ihap_merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
        ihap_merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction
endpackage

// ===== ihap_dec_if.sv
// decode signals passed between the top and the address decoder
`timescale 1ns/10ps
interface ihap_dec_if;
    logic [19:0] sa;
    logic [15:0] io_base;
    logic [23:0] mem_base;
    logic mem_en;
    logic aen;
    logic io_strobe;
    logic mem_strobe;
    logic cs_n;
    logic io_hit;
    logic mem_hit;
    logic [3:0] port;
    logic [11:0] space;
    modport dec (input sa, io_base, mem_base, mem_en, aen, io_strobe, mem_strobe, cs_n,
                 output io_hit, mem_hit, port, space);
    modport core (output sa, io_base, mem_base, mem_en, aen, io_strobe, mem_strobe, cs_n,
                  input io_hit, mem_hit, port, space);
endinterface

// ===== ihap_decode.sv
// address decoder for io and memory cycles
`timescale 1ns/10ps
module ihap_decode
    import ihap_pkg::*;
(
    // decode view
    ihap_dec_if.dec d
);
    // io cycle: aen low, io strobe low, sa15..4 equal to the io base
    assign d.io_hit = !d.aen && d.io_strobe && (d.sa[15:4] == d.io_base[15:4]);
    // memory cycle: enabled, chip select low, strobe low, block match
    assign d.mem_hit = d.mem_en && !d.cs_n && d.mem_strobe && (d.sa[19:12] == d.mem_base[19:12]);
    // port within the 16 io locations, space offset within the block
    assign d.port = {d.sa[3:1], 1'b0};
    assign d.space = d.sa[11:0];
endmodule

// ===== ihap_top.sv
// top of the isa host access port: bus cycles, io ports and register space
`timescale 1ns/10ps
module ihap_top
    import ihap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // isa bus
    input wire logic [19:0] sa,
    input wire logic [15:0] sd_in,
    output logic [15:0] sd_out,
    output logic sd_oe,
    input wire logic sbhe_n,
    input wire logic aen,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic chip_select_n,
    // io base relocation
    input wire logic [15:0] cfg_io_base,
    input wire logic cfg_io_base_load,
    // device status
    input wire logic init_done,
    input wire logic ext_logic_present,
    input wire logic transmit_ready_now,
    // mode
    output logic memory_enable,
    output logic system_address_select,
    // receive frame buffer
    output logic rx_rd,
    output logic [10:0] rx_addr,
    input wire logic [15:0] rx_rdata,
    input wire logic rx_frame_new,
    // transmit frame buffer
    output logic tx_wr,
    output logic [1:0] tx_be,
    output logic [15:0] tx_data,
    // transmit bid
    output logic tx_bid,
    output logic [15:0] tx_cmd,
    output logic [15:0] tx_len,
    // event queue
    output logic evq_rd,
    input wire logic [15:0] evq_data,
    // internal register space
    output logic reg_rd,
    output logic [11:0] reg_raddr,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic [11:0] reg_waddr,
    output logic [1:0] reg_be,
    output logic [15:0] reg_wdata
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ihap_dec_if d ();
    ihap_regs_t r_q;
    ihap_regs_t r_d;
    logic take;
    logic is_rd;
    logic odd8;
    logic wide;
    logic [1:0] be;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic [11:0] space;
    logic [11:0] ptr_addr;
    logic io_ptr_sel;
    logic reg_port;
    logic rx_win;
    logic tx_win;
    logic rx_area;
    logic rx_rand;
    logic [10:0] rx_off;
    logic [15:0] len_new;
    logic len_ok;
    logic [15:0] base_hi;
    logic [15:0] bus_st;
    logic [15:0] self_st;
    logic rd_strobe;

    // ------------------------------------------------------------
    // address decoder
    // ------------------------------------------------------------
    // feed the decoder from pins and mode registers
    assign d.sa = sa;
    assign d.io_base = r_q.io_base;
    assign d.mem_base = r_q.mem_base;
    assign d.mem_en = r_q.bus_ctl[BC_MEM_EN];
    assign d.aen = aen;
    assign d.io_strobe = !ior_n || !iow_n;
    assign d.mem_strobe = !mem_read_strobe_n || !mem_write_strobe_n;
    assign d.cs_n = chip_select_n;

    ihap_decode u_dec (
        .d(d)
    );

    // ------------------------------------------------------------
    // access view
    // ------------------------------------------------------------
    // classify the cycle and map io ports onto register space
    always_comb begin
        take = (r_q.st == ST_IDLE) && (d.mem_hit || d.io_hit);
        is_rd = d.mem_hit ? !mem_read_strobe_n : !ior_n;
        be = {!sbhe_n || sa[0], !sa[0]};
        wide = (be == 2'b11);
        odd8 = sa[0] && sbhe_n; // 8-bit host moves the odd byte on the low lane
        wdat = ihap_swap(sd_in, odd8);
        ptr_addr = r_q.ptr[11:0];
        io_ptr_sel = !d.mem_hit && (d.port == IO_PTR);
        reg_port = !d.mem_hit && ((d.port == IO_REG0) || (d.port == IO_REG1));
        space = d.space;
        if (!d.mem_hit) begin
            unique case (d.port)
                IO_DATA0, IO_DATA1: space = is_rd ? SP_RX_STAT : SP_TX_FRAME;
                IO_TX_CMD: space = SP_TX_CMD;
                IO_TX_LEN: space = SP_TX_LEN;
                IO_EVQ: space = SP_EVQ;
                IO_PTR: space = ptr_addr;
                IO_REG0: space = ptr_addr;
                IO_REG1: space = r_q.ptr[PTR_AUTOINC] ? ptr_addr : ptr_addr + PTR_STEP;
            endcase
        end
        rx_win = (space >= SP_RX_STAT) && (space < SP_TX_FRAME);
        tx_win = (space >= SP_TX_FRAME);
        rx_area = rx_win && is_rd && !io_ptr_sel;
        rx_rand = d.mem_hit && (space < SP_RX_RAND_END);
        rx_off = rx_rand ? 11'(space - SP_RX_STAT) : r_q.rx_seq;
        len_new = ihap_merge(r_q.tx_len, wdat, be);
        len_ok = (len_new >= LEN_MIN) && (len_new <= LEN_MAX);
        base_hi = ihap_merge({8'h00, r_q.mem_base[23:16]}, wdat, be);
    end

    // status words built from live device state
    always_comb begin
        bus_st = 16'h0000;
        bus_st[BS_BID_ERR] = r_q.bid_err;
        bus_st[BS_TX_RDY] = transmit_ready_now;
        self_st = 16'h0000;
        self_st[SS_INIT_DONE] = init_done;
        self_st[SS_EXT_LOGIC] = ext_logic_present;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // select read data and issue read strobes to the owners
    always_comb begin
        rdat = 16'h0000;
        rx_rd = 1'b0;
        evq_rd = 1'b0;
        reg_rd = 1'b0;
        if (io_ptr_sel) begin
            rdat = {r_q.ptr[PTR_AUTOINC], PTR_FIXED, r_q.ptr[11:0]};
        end else if (rx_area) begin
            rdat = rx_rdata;
            rx_rd = take && is_rd;
        end else if (!tx_win && !rx_win) begin
            unique case (space)
                SP_EVQ: begin
                    rdat = evq_data;
                    evq_rd = take && is_rd;
                end
                SP_BUS_ST: rdat = bus_st;
                SP_SELF_ST: rdat = self_st;
                SP_BUS_CTL: rdat = r_q.bus_ctl;
                SP_MEM_BASE_LO: rdat = r_q.mem_base[15:0];
                SP_MEM_BASE_HI: rdat = {8'h00, r_q.mem_base[23:16]};
                SP_TX_CMD, SP_TX_LEN: rdat = 16'h0000;
                default: begin
                    rdat = reg_rdata;
                    reg_rd = take && is_rd;
                end
            endcase
        end
    end
    assign rx_addr = rx_off;
    assign reg_raddr = space;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // cycle tracking, writes, pointer stepping and status flags
    always_comb begin
        r_d = r_q;
        r_d.tx_wr = 1'b0;
        r_d.tx_bid = 1'b0;
        r_d.reg_wr = 1'b0;
        unique case (r_q.st)
            ST_IDLE: begin
                if (take) begin
                    r_d.st = ST_ACT;
                end
            end
            ST_ACT: begin
                if (!d.io_strobe && !d.mem_strobe) begin
                    r_d.st = ST_IDLE;
                end
            end
        endcase
        if (take) begin
            r_d.rd = is_rd;
            if (is_rd) begin
                r_d.sd = ihap_swap(rdat, odd8);
            end
            if (rx_area) begin
                r_d.rx_seq = rx_off + (wide ? RX_STEP_WORD : RX_STEP_BYTE);
            end
            if (reg_port && (wide || sa[0]) && r_q.ptr[PTR_AUTOINC]) begin
                r_d.ptr[11:0] = ptr_addr + PTR_STEP;
            end
            if (!is_rd) begin
                if (io_ptr_sel) begin
                    r_d.ptr = ihap_merge(r_q.ptr, wdat, be);
                end else if (tx_win) begin
                    r_d.tx_wr = 1'b1;
                    r_d.tx_be = be;
                    r_d.tx_data = wdat;
                end else if (!rx_win) begin
                    unique case (space)
                        SP_TX_CMD: r_d.tx_cmd = ihap_merge(r_q.tx_cmd, wdat, be);
                        SP_TX_LEN: begin
                            r_d.tx_len = len_new;
                            if (be[1] && len_ok) begin
                                r_d.tx_bid = 1'b1;
                                r_d.bid_err = 1'b0;
                            end else if (be[1]) begin
                                r_d.bid_err = 1'b1;
                            end
                        end
                        SP_BUS_CTL: r_d.bus_ctl = ihap_merge(r_q.bus_ctl, wdat, be);
                        SP_MEM_BASE_LO: r_d.mem_base[15:0] = ihap_merge(r_q.mem_base[15:0], wdat, be);
                        SP_MEM_BASE_HI: r_d.mem_base[23:16] = base_hi[7:0];
                        SP_EVQ, SP_BUS_ST, SP_SELF_ST: r_d.reg_wr = 1'b0;
                        default: begin
                            r_d.reg_wr = 1'b1;
                            r_d.reg_waddr = space;
                            r_d.reg_be = be;
                            r_d.reg_wdata = wdat;
                        end
                    endcase
                end
            end
        end
        // a new frame restarts the sequential read position
        if (rx_frame_new) begin
            r_d.rx_seq = 11'h000;
        end
        // relocation keeps the base on a 16-byte boundary
        if (cfg_io_base_load) begin
            r_d.io_base = {cfg_io_base[15:4], 4'h0};
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // read data is driven the cycle after the strobe is taken
    assign rd_strobe = !ior_n || !mem_read_strobe_n;
    assign sd_out = r_q.sd;
    assign sd_oe = (r_q.st == ST_ACT) && r_q.rd && rd_strobe;
    assign memory_enable = r_q.bus_ctl[BC_MEM_EN];
    assign system_address_select = r_q.bus_ctl[BC_SYS_ADDR];
    assign tx_wr = r_q.tx_wr;
    assign tx_be = r_q.tx_be;
    assign tx_data = r_q.tx_data;
    assign tx_bid = r_q.tx_bid;
    assign tx_cmd = r_q.tx_cmd;
    assign tx_len = r_q.tx_len;
    assign reg_wr = r_q.reg_wr;
    assign reg_waddr = r_q.reg_waddr;
    assign reg_be = r_q.reg_be;
    assign reg_wdata = r_q.reg_wdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_len_write;
        take && !is_rd && !io_ptr_sel && (space == SP_TX_LEN) && be[1];
    endsequence
    sequence s_tx_write;
        take && !is_rd && !io_ptr_sel && tx_win;
    endsequence

    logic bid_err_seen;
    assign bid_err_seen = r_q.bid_err && !tx_bid && bus_st[BS_BID_ERR];
    property p_bid_bad;
        s_len_write ##0 !len_ok |=> bid_err_seen;
    endproperty
    a_bid_bad: assert property (p_bid_bad) else $error("bad length did not set bid error");

    property p_bid_ok;
        s_len_write ##0 len_ok |=> tx_bid && !r_q.bid_err ##1 !tx_bid;
    endproperty
    a_bid_ok: assert property (p_bid_ok) else $error("valid length did not pulse tx_bid");

    property p_ptr_view;
        take && is_rd && io_ptr_sel
            |=> ihap_swap(sd_out, $past(odd8)) == {$past(r_q.ptr[PTR_AUTOINC]), PTR_FIXED, $past(ptr_addr)};
    endproperty
    a_ptr_view: assert property (p_ptr_view) else $error("pointer read back wrong");

    property p_autoinc;
        take && reg_port && wide && r_q.ptr[PTR_AUTOINC] |=> r_q.ptr[11:0] == $past(ptr_addr) + PTR_STEP;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("pointer did not step by one word");

    property p_rx_rand;
        take && rx_area && d.mem_hit && (space < SP_RX_RAND_END) |-> rx_rd && (rx_addr == 11'(space - SP_RX_STAT));
    endproperty
    a_rx_rand: assert property (p_rx_rand) else $error("random receive read used wrong offset");

    property p_rx_seq;
        take && rx_area && !d.mem_hit && wide && !rx_frame_new |=> r_q.rx_seq == $past(rx_addr) + RX_STEP_WORD;
    endproperty
    a_rx_seq: assert property (p_rx_seq) else $error("sequential receive position did not advance");

    property p_mem_decode;
        d.mem_hit |-> memory_enable && !chip_select_n && (!mem_read_strobe_n || !mem_write_strobe_n)
            && (sa[19:12] == r_q.mem_base[19:12]);
    endproperty
    a_mem_decode: assert property (p_mem_decode) else $error("memory cycle taken without its conditions");

    property p_reset_mode;
        disable iff (1'b0) rst |=> !memory_enable && (r_q.io_base == IO_BASE_RST);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset did not restore io mode");

    property p_no_wait;
        take && is_rd |=> (r_q.st == ST_ACT) && (sd_out == ihap_swap($past(rdat), $past(odd8)));
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("read data late");

    property p_tx_push;
        s_tx_write |=> tx_wr && (tx_data == $past(wdat)) ##1 !tx_wr;
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("frame write not passed on");
endmodule

// ===== ihap_host_model.sv
// host processor model that runs io and memory cycles on the isa bus
`timescale 1ns/10ps
module ihap_host_model (
    // clock
    input wire logic clk,
    // isa bus
    output logic [19:0] sa,
    output logic [15:0] sd_in,
    output logic sbhe_n,
    output logic aen,
    output logic ior_n,
    output logic iow_n,
    output logic mrd_n,
    output logic mwr_n,
    output logic cs_n,
    input wire logic [15:0] sd_out
);
    // idle bus: strobes high, word lanes, no dma
    initial begin
        sa = 20'h0;
        sd_in = 16'h0;
        sbhe_n = 1'b0; // word lanes only, no byte switching
        aen = 1'b0;
        {ior_n, iow_n, mrd_n, mwr_n, cs_n} = 5'h1f;
    end
    // one even word cycle; strobe held two edges, then released with data inverted
    task automatic acc(input logic io, input logic wr, input logic [19:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        #1;
        sa = a; // even word address
        sd_in = d; // one word per cycle, no double words
        if (io) begin
            ior_n = wr;
            iow_n = !wr;
        end else begin
            cs_n = 1'b0;
            mrd_n = wr;
            mwr_n = !wr;
        end
        repeat (2) @(posedge clk);
        #1;
        q = sd_out;
        {ior_n, iow_n, mrd_n, mwr_n, cs_n} = 5'h1f;
        sd_in = ~d;
        sa = ~a;
    endtask
endmodule

// ===== testbench.sv
// self-checking testbench of the isa host access port
`timescale 1ns/10ps
module testbench;
    import ihap_pkg::*;
    logic clk = 0, rst = 1, rdy = 1, fnew = 0;
    logic [19:0] sa;
    logic [15:0] sd_in, sd_out, tx_cmd, tx_len, q, tx_data, reg_wdata;
    logic sbhe_n, aen, ior_n, iow_n, mrd_n, mwr_n, cs_n, mem_en, sys_sel, tx_bid, rx_rd;
    logic sd_oe, tx_wr, evq_rd, reg_wr, ld = 0;
    logic [1:0] tx_be;
    logic [10:0] rx_addr;
    logic [11:0] reg_raddr, reg_waddr;
    int failures = 0, num_checks = 0, bids = 0, oes = 0, txws = 0, rxrs = 0, evrs = 0, regws = 0;
    // clock and pulse counters
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (tx_bid === 1'b1) bids <= bids + 1;
        if (sd_oe === 1'b1) oes <= oes + 1;
        if (tx_wr === 1'b1) txws <= txws + 1;
        if (rx_rd === 1'b1) rxrs <= rxrs + 1;
        if (evq_rd === 1'b1) evrs <= evrs + 1;
        if (reg_wr === 1'b1) regws <= regws + 1;
    end
    // host model and design
    ihap_host_model host (.clk(clk), .sa(sa), .sd_in(sd_in), .sbhe_n(sbhe_n), .aen(aen), .ior_n(ior_n),
        .iow_n(iow_n), .mrd_n(mrd_n), .mwr_n(mwr_n), .cs_n(cs_n), .sd_out(sd_out));
    ihap_top DUT (.clk(clk), .rst(rst), .sa(sa), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .sbhe_n(sbhe_n),
        .aen(aen), .ior_n(ior_n), .iow_n(iow_n), .mem_read_strobe_n(mrd_n), .mem_write_strobe_n(mwr_n),
        .chip_select_n(cs_n), .cfg_io_base(16'h0248), .cfg_io_base_load(ld), .init_done(1'b1),
        .ext_logic_present(1'b1), .transmit_ready_now(rdy), .memory_enable(mem_en),
        .system_address_select(sys_sel), .rx_rd(rx_rd), .rx_addr(rx_addr), .rx_rdata({5'h0, rx_addr}),
        .rx_frame_new(fnew), .tx_wr(tx_wr), .tx_be(tx_be), .tx_data(tx_data), .tx_bid(tx_bid), .tx_cmd(tx_cmd),
        .tx_len(tx_len), .evq_rd(evq_rd), .evq_data(16'h0004), .reg_rd(), .reg_raddr(reg_raddr),
        .reg_rdata({4'h0, reg_raddr}), .reg_wr(reg_wr), .reg_waddr(reg_waddr), .reg_be(), .reg_wdata(reg_wdata));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // io port access at base 300h; register write through pointer
    task automatic io(input logic wr, input logic [3:0] p, input logic [15:0] d);
        host.acc(1'b1, wr, {16'h0030, p}, d, q);
    endtask
    task automatic rset(input logic [11:0] a, input logic [15:0] d);
        io(1, IO_PTR, {4'h0, a});
        io(1, IO_REG0, d);
    endtask
    task automatic t_pointer;
        io(1, IO_PTR, 16'h8138);
        io(0, IO_PTR, 0);
        chk("pointer", q, 16'hb138);
        io(0, IO_EVQ, 0);
        chk("event queue", q, 16'h0004);
        chk("event queue reads", 16'(evrs), 1);
        chk("output enable cycles", 16'(oes), 2);
        $display("pointer test done");
    endtask
    task automatic t_bid;
        io(1, IO_TX_CMD, 16'h00c0);
        io(1, IO_TX_LEN, 16'h0040);
        chk("bid count", 16'(bids), 1);
        chk("tx cmd", tx_cmd, 16'h00c0);
        chk("tx len", tx_len, 16'h0040);
        io(1, IO_TX_LEN, 16'h0003);
        chk("bid count bad", 16'(bids), 1);
        io(1, IO_PTR, 16'h0138);
        io(0, IO_REG0, 0);
        chk("bus status", {14'h0, q[8:7]}, 16'h3);
        rdy = 0;
        io(0, IO_REG0, 0);
        chk("bus status busy", {14'h0, q[8:7]}, 16'h1);
        io(1, IO_TX_LEN, 16'h05ee);
        chk("bid count max", 16'(bids), 2);
        io(0, IO_REG0, 0);
        chk("bid error cleared", {14'h0, q[8:7]}, 16'h0);
        rdy = 1; // frame goes in only once ready
        io(1, IO_DATA0, 16'h0123);
        io(1, IO_DATA0, 16'h4567);
        chk("frame data", tx_data, 16'h4567);
        chk("frame lanes", {14'h0, tx_be}, 16'h3);
        chk("frame writes", 16'(txws), 2);
        $display("bid test done");
    endtask
    task automatic t_regs;
        rset(12'h150, 16'h1234);
        chk("reg write addr", {4'h0, reg_waddr}, 16'h0150);
        chk("reg write data", reg_wdata, 16'h1234);
        chk("reg write count", 16'(regws), 1);
        io(1, IO_PTR, 16'h8150);
        io(0, IO_REG0, 0);
        chk("reg port 0", q, 16'h0150);
        io(0, IO_REG1, 0);
        chk("reg port 1 stepped", q, 16'h0152);
        io(0, IO_PTR, 0);
        chk("pointer stepped", q, 16'hb154);
        io(1, IO_PTR, 16'h0150);
        io(0, IO_REG1, 0);
        chk("reg port 1 fixed", q, 16'h0152);
        io(1, IO_PTR, {4'h0, SP_SELF_ST});
        io(0, IO_REG0, 0);
        chk("self status", q, 16'h0880);
        $display("register test done");
    endtask
    task automatic t_rx;
        @(posedge clk);
        #1 fnew = 1;
        @(posedge clk);
        #1 fnew = 0;
        io(0, IO_DATA0, 0);
        chk("rx status", q, 16'h0000);
        io(0, IO_DATA1, 0);
        chk("rx length", q, 16'h0002);
        io(0, IO_DATA0, 0);
        chk("rx data", q, 16'h0004);
        chk("rx reads", 16'(rxrs), 3);
        $display("receive test done");
    endtask
    task automatic t_mem;
        chk("mem enable reset", {15'h0, mem_en}, 0);
        rset(SP_MEM_BASE_HI, 16'h000d);
        rset(SP_MEM_BASE_LO, 16'h0000);
        rset(SP_BUS_CTL, 16'h0600);
        chk("mode bits", {14'h0, mem_en, sys_sel}, 16'h3);
        host.acc(0, 0, 20'hd0410, 0, q);
        chk("random read", q, 16'h0010);
        host.acc(0, 0, 20'hd047a, 0, q);
        chk("sequential read", q, 16'h0012);
        chk("rx reads mem", 16'(rxrs), 5);
        host.acc(0, 1, 20'hd0a00, 16'h89ab, q);
        chk("mem frame data", tx_data, 16'h89ab);
        chk("mem frame writes", 16'(txws), 3);
        $display("memory test done");
    endtask
    task automatic t_reset;
        rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        chk("mem enable after reset", {15'h0, mem_en}, 0);
        io(0, IO_PTR, 0);
        chk("pointer after reset", q, 16'h3000);
        ld = 1;
        @(posedge clk);
        #1 ld = 0;
        host.acc(1, 1, {16'h0024, IO_PTR}, 16'h0044, q);
        host.acc(1, 0, {16'h0024, IO_PTR}, 0, q);
        chk("moved io base", q, 16'h3044);
        $display("reset test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // main sequence with a bound on the whole run
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 0;
        t_pointer;
        t_bid;
        t_regs;
        t_rx;
        t_mem;
        t_reset;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
endmodule
